// ==== pcd_data_phase.sv ====
/*
  Device-side data phase sequencer for packet commands: PIO in/out,
  DMA in/out, status and bus release, with an AHB-Lite register slave.
  Assumes the transport layer holds off tl_done until a requested frame
  has gone out, or until a Data frame has been taken in while
  tl_rx_accept is high, and that the back end drives its flags steadily.
*/
// Added by the designer: the AHB-Lite slave port and the register offsets.
// Contract
// - PIO-in prepare: block ready goes to setup
// - PIO-in not ready, overlap on: release
// - PIO-in setup frame: busy 0/1, request 1/0, intr
// - PIO-in setup sent: go send data
// - Send PIO data, then back to prepare
// - PIO-out prepare: can accept goes to setup
// - PIO-out all received or error: status
// - PIO-out cannot accept, overlap on: release
// - PIO-out setup frame: busy 0/1, request 1/0, intr
// - PIO-out setup sent: receive data frame
// - PIO data received: back to prepare
// - DMA-in data ready: send data
// - DMA-in all sent or error: status
// - DMA-in not ready, overlap on: release
// - DMA data frame at most 2048 dwords
// - DMA-out able to receive: send activate
// - DMA-out all arrived or error: status
// - DMA-out cannot accept, overlap on: release
// - Activate sent: receive DMA data
// - DMA data received: back to prepare
// - Status frame with interrupt, then idle
// - Release frame, interrupt if enabled, idle
`timescale 1ns/1ps

module pcd_data_phase
  import pcd_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  output logic              tl_req_valid,
  output pcd_fis_req_t      tl_req,
  input  wire logic         tl_done,
  output logic              tl_rx_accept,
  input  wire pcd_backend_t be,
  output logic              cmd_active
);

  pcd_state_t   state;
  pcd_state_t   next_state;
  pcd_proto_t   proto;
  logic         ovl_en;
  logic         relie;
  logic [31:0]  xfer;
  logic [31:0]  regc;
  logic         done_flag;
  logic         released_flag;
  logic         err_flag;
  logic [11:0]  frame_cnt;
  logic         ap_wr;
  logic         ap_ok;
  logic [7:0]   ap_addr;
  logic         take;
  logic         wr_ctrl;
  logic         wr_stat;
  logic         start_cmd;
  logic         in_prep;

  function automatic logic reg_hit(input logic ok, input logic [7:0] a,
                                   input logic [7:0] ofs);
    reg_hit = ok && (a == ofs);
  endfunction : reg_hit

  function automatic logic [11:0] clamp_dw(input logic [11:0] dw);
    if (dw == 12'h000 || dw > MAX_DATA_DWORDS) begin
      clamp_dw = MAX_DATA_DWORDS;
    end else begin
      clamp_dw = dw;
    end
  endfunction : clamp_dw

  // Frame contents for the frame that a state asks for
  function automatic pcd_fis_req_t fis_for(input pcd_state_t s,
                                           input logic [31:0] x,
                                           input logic [31:0] rc,
                                           input logic ie);
    pcd_fis_req_t f;
    f             = '0;
    f.status      = rc[REGC_ST_LSB +: 8];
    f.error       = rc[REGC_ER_LSB +: 8];
    f.byte_count  = x[XFER_BC_LSB +: 16];
    f.dword_count = clamp_dw(x[XFER_DW_LSB +: 12]);
    case (s)
      pio_in_setup_state,
      pio_out_setup_state: begin
        f.kind      = FIS_PIO_SETUP;
        f.init_busy     = 1'b0;
        f.init_data_req = 1'b1;
        f.intr          = 1'b1;
        f.end_busy      = 1'b1;
        f.end_data_req  = 1'b0;
      end
      send_pio_data_state: begin
        f.kind = FIS_DATA;
      end
      send_dma_data_state: begin
        f.kind = FIS_DATA;
      end
      send_dma_activate_state: begin
        f.kind = FIS_DMA_ACT;
      end
      send_status_state: begin
        f.kind = FIS_REG;
        f.intr = 1'b1;
      end
      release_state: begin
        f.kind        = FIS_REG;
        f.bus_release = 1'b1;
        f.intr        = ie;
      end
      default: begin
        f.kind = FIS_NONE;
      end
    endcase
    return f;
  endfunction : fis_for

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel && htrans[1] && hready;

  always_ff @(posedge clk) begin
    if (reset) begin
      ap_wr   <= 1'b0;
      ap_ok   <= 1'b0;
      ap_addr <= 8'h00;
    end else begin
      ap_wr <= take && hwrite;
      if (take) begin
        ap_ok   <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
        ap_addr <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (haddr[31:8] == 24'h000000) begin
        case (haddr[7:0])
          OFS_CTRL: begin
            hrdata[CTRL_PROTO_LSB +: 2] <= proto;
            hrdata[CTRL_OVL_BIT]        <= ovl_en;
            hrdata[CTRL_RELIE_BIT]      <= relie;
          end
          OFS_STAT: begin
            hrdata[STAT_STATE_LSB +: 14] <= state;
            hrdata[STAT_DONE_BIT]        <= done_flag;
            hrdata[STAT_RELEASED_BIT]    <= released_flag;
            hrdata[STAT_ERR_BIT]         <= err_flag;
            hrdata[STAT_CNT_LSB +: 12]   <= frame_cnt;
          end
          OFS_XFER: begin
            hrdata <= xfer;
          end
          OFS_REGC: begin
            hrdata <= regc;
          end
          default: begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign wr_ctrl   = ap_wr && reg_hit(ap_ok, ap_addr, OFS_CTRL);
  assign wr_stat   = ap_wr && reg_hit(ap_ok, ap_addr, OFS_STAT);
  assign start_cmd = wr_ctrl && hwdata[CTRL_START_BIT] &&
                     (state == device_idle_state);

  // Mode bits change only while idle
  always_ff @(posedge clk) begin
    if (reset) begin
      proto  <= PROTO_PIO_IN;
      ovl_en <= 1'b0;
      relie  <= 1'b0;
    end else if (wr_ctrl && state == device_idle_state) begin
      proto  <= pcd_proto_t'(hwdata[CTRL_PROTO_LSB +: 2]);
      ovl_en <= hwdata[CTRL_OVL_BIT];
      relie  <= hwdata[CTRL_RELIE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      xfer <= XFER_RST;
      regc <= REGC_RST;
    end else if (ap_wr) begin
      if (reg_hit(ap_ok, ap_addr, OFS_XFER)) begin
        xfer <= hwdata;
      end
      if (reg_hit(ap_ok, ap_addr, OFS_REGC)) begin
        regc <= {16'h0000, hwdata[15:0]};
      end
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      device_idle_state: begin
        if (start_cmd) begin
          case (pcd_proto_t'(hwdata[CTRL_PROTO_LSB +: 2]))
            PROTO_PIO_IN:  next_state = pio_in_prepare_state;
            PROTO_PIO_OUT: next_state = pio_out_prepare_state;
            PROTO_DMA_IN:  next_state = dma_in_prepare_state;
            default:       next_state = dma_out_prepare_state;
          endcase
        end
      end
      pio_in_prepare_state: begin
        if (be.finished || be.error) begin
          next_state = send_status_state;
        end else if (be.ready) begin
          next_state = pio_in_setup_state;
        end else if (ovl_en) begin
          next_state = release_state;
        end
      end
      pio_in_setup_state: begin
        if (tl_done) next_state = send_pio_data_state;
      end
      send_pio_data_state: begin
        if (tl_done) next_state = pio_in_prepare_state;
      end
      pio_out_prepare_state: begin
        if (be.finished || be.error) begin
          next_state = send_status_state;
        end else if (be.ready) begin
          next_state = pio_out_setup_state;
        end else if (ovl_en) begin
          next_state = release_state;
        end
      end
      pio_out_setup_state: begin
        if (tl_done) next_state = receive_pio_data_state;
      end
      receive_pio_data_state: begin
        if (tl_done) next_state = pio_out_prepare_state;
      end
      dma_in_prepare_state: begin
        if (be.finished || be.error) begin
          next_state = send_status_state;
        end else if (be.ready) begin
          next_state = send_dma_data_state;
        end else if (ovl_en) begin
          next_state = release_state;
        end
      end
      send_dma_data_state: begin
        if (tl_done) next_state = dma_in_prepare_state;
      end
      dma_out_prepare_state: begin
        if (be.finished || be.error) begin
          next_state = send_status_state;
        end else if (be.ready) begin
          next_state = send_dma_activate_state;
        end else if (ovl_en) begin
          next_state = release_state;
        end
      end
      send_dma_activate_state: begin
        if (tl_done) next_state = receive_dma_data_state;
      end
      receive_dma_data_state: begin
        if (tl_done) next_state = dma_out_prepare_state;
      end
      send_status_state: begin
        if (tl_done) next_state = device_idle_state;
      end
      release_state: begin
        if (tl_done) next_state = device_idle_state;
      end
      default: begin
        next_state = device_idle_state;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= device_idle_state;
    end else begin
      state <= next_state;
    end
  end

  // Frame request registered alongside the state
  always_ff @(posedge clk) begin
    if (reset) begin
      tl_req <= '0;
    end else begin
      tl_req <= fis_for(next_state, xfer, regc, relie);
    end
  end

  assign tl_req_valid = (tl_req.kind != FIS_NONE);
  assign tl_rx_accept = (state == receive_pio_data_state) ||
                        (state == receive_dma_data_state);
  assign cmd_active   = (state != device_idle_state);
  assign in_prep      = (state == pio_in_prepare_state) ||
                        (state == pio_out_prepare_state) ||
                        (state == dma_in_prepare_state) ||
                        (state == dma_out_prepare_state);

  // Sticky outcome flags, set wins over write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      done_flag     <= 1'b0;
      released_flag <= 1'b0;
      err_flag      <= 1'b0;
    end else begin
      done_flag <= (state == send_status_state && tl_done) ||
                   (done_flag && !(wr_stat && hwdata[STAT_DONE_BIT]));
      released_flag <= (state == release_state && tl_done) ||
                       (released_flag && !(wr_stat && hwdata[STAT_RELEASED_BIT]));
      err_flag  <= (in_prep && be.error) ||
                   (err_flag && !(wr_stat && hwdata[STAT_ERR_BIT]));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_cnt <= 12'h000;
    end else if (start_cmd) begin
      frame_cnt <= 12'h000;
    end else if (tl_done && (tl_req_valid || tl_rx_accept)) begin
      frame_cnt <= frame_cnt + 12'h001;
    end
  end

  chk_pin_ready_go: assert property (@(posedge clk) disable iff (reset)
    state == pio_in_prepare_state && be.ready && !be.finished && !be.error
    |=> state == pio_in_setup_state)
    else $error("pio in ready did not reach setup");

  chk_pin_setup_frame: assert property (@(posedge clk) disable iff (reset)
    state == pio_in_setup_state |-> tl_req_valid &&
    tl_req.kind == FIS_PIO_SETUP && !tl_req.init_busy && tl_req.init_data_req &&
    tl_req.intr && tl_req.end_busy && !tl_req.end_data_req &&
    tl_req.byte_count == xfer[XFER_BC_LSB +: 16])
    else $error("pio in setup frame fields wrong");

  chk_pin_data_loop: assert property (@(posedge clk) disable iff (reset)
    state == pio_in_setup_state && tl_done
    |=> state == send_pio_data_state && tl_req.kind == FIS_DATA)
    else $error("pio in setup did not lead to data");

  chk_pin_data_back: assert property (@(posedge clk) disable iff (reset)
    state == send_pio_data_state && tl_done |=> state == pio_in_prepare_state)
    else $error("pio in data did not loop back");

  chk_pout_setup_frame: assert property (@(posedge clk) disable iff (reset)
    $rose(state == pio_out_setup_state) |-> tl_req.kind == FIS_PIO_SETUP &&
    tl_req.init_data_req && tl_req.end_busy && tl_req.intr && !tl_req.bus_release)
    else $error("pio out setup frame fields wrong");

  chk_pout_rx_loop: assert property (@(posedge clk) disable iff (reset)
    state == pio_out_setup_state && tl_done
    |=> state == receive_pio_data_state && tl_rx_accept && !tl_req_valid)
    else $error("pio out receive not entered");

  chk_pout_rx_back: assert property (@(posedge clk) disable iff (reset)
    state == receive_pio_data_state && tl_done |=> state == pio_out_prepare_state)
    else $error("pio out receive did not return");

  chk_dma_len_cap: assert property (@(posedge clk) disable iff (reset)
    state == send_dma_data_state |-> tl_req.kind == FIS_DATA &&
    tl_req.dword_count <= 12'h800 && tl_req.dword_count != 12'h000)
    else $error("dma data frame too long");

  chk_dma_out_seq: assert property (@(posedge clk) disable iff (reset)
    state == send_dma_activate_state && tl_done
    |=> state == receive_dma_data_state && tl_rx_accept && !tl_req_valid)
    else $error("activate did not lead to receive");

  chk_status_intr: assert property (@(posedge clk) disable iff (reset)
    state == send_status_state |-> tl_req.kind == FIS_REG && tl_req.intr &&
    !tl_req.bus_release)
    else $error("status frame without interrupt");

  chk_status_idle: assert property (@(posedge clk) disable iff (reset)
    state == send_status_state && tl_done |=> state == device_idle_state
    ##1 done_flag)
    else $error("status did not end in idle");

  chk_release_intr: assert property (@(posedge clk) disable iff (reset)
    state == release_state |-> tl_req.bus_release && tl_req.intr == relie)
    else $error("release frame interrupt wrong");

  chk_no_overlap: assert property (@(posedge clk) disable iff (reset)
    in_prep && !ovl_en && !be.ready && !be.finished && !be.error
    |=> $stable(state))
    else $error("prepare state left without cause");

  chk_err_status: assert property (@(posedge clk) disable iff (reset)
    in_prep && be.error |=> state == send_status_state)
    else $error("error did not lead to status");

endmodule : pcd_data_phase

// ==== pcd_host_model.sv ====
/*
  Behavioural far end: transport layer plus host, answering frame
  requests and receive windows with a done pulse after a set delay.
  Assumes the sequencer holds a request until it sees the pulse.
*/
`timescale 1ns/1ps

module pcd_host_model
  import pcd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       tl_req_valid,
  input  wire logic       tl_rx_accept,
  input  wire logic [3:0] dly,
  output logic            tl_done
);
  logic [3:0] wait_cnt;

  // One pulse per request, dly idle cycles first
  always_ff @(posedge clk) begin
    if (reset || tl_done || !(tl_req_valid || tl_rx_accept)) begin
      wait_cnt <= 4'h0;
      tl_done  <= 1'b0;
    end else if (wait_cnt == dly) begin
      tl_done <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : pcd_host_model

// ==== pcd_pkg.sv ====
/*
  Shared constants and types for the packet command data phase sequencer.
  Assumes an AHB-Lite master on the register side and a transport layer
  that accepts one frame request at a time and pulses a done strobe.
*/
package pcd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_XFER = 8'h08;
  localparam logic [7:0] OFS_REGC = 8'h0c;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_PROTO_LSB = 1;
  localparam int CTRL_OVL_BIT   = 3;
  localparam int CTRL_RELIE_BIT = 4;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DONE_BIT  = 16;
  localparam int STAT_RELEASED_BIT = 17;
  localparam int STAT_ERR_BIT   = 18;
  localparam int STAT_CNT_LSB   = 20;

  // Transfer size and register content fields
  localparam int XFER_BC_LSB = 0;
  localparam int XFER_DW_LSB = 16;
  localparam int REGC_ST_LSB = 0;
  localparam int REGC_ER_LSB = 8;

  // Reset values
  localparam logic [31:0] XFER_RST = 32'h0000_0000;
  localparam logic [31:0] REGC_RST = 32'h0000_0050;

  // Largest data frame in dwords
  localparam logic [11:0] MAX_DATA_DWORDS = 12'h800;

  typedef enum logic [1:0] {
    PROTO_PIO_IN  = 2'h0,
    PROTO_PIO_OUT = 2'h1,
    PROTO_DMA_IN  = 2'h2,
    PROTO_DMA_OUT = 2'h3
  } pcd_proto_t;

  typedef enum logic [2:0] {
    FIS_NONE      = 3'h0,
    FIS_PIO_SETUP = 3'h1,
    FIS_DATA      = 3'h2,
    FIS_DMA_ACT   = 3'h3,
    FIS_REG       = 3'h4
  } pcd_fis_t;

  typedef enum logic [13:0] {
    device_idle_state       = 14'h0001,
    pio_in_prepare_state    = 14'h0002,
    pio_in_setup_state      = 14'h0004,
    send_pio_data_state     = 14'h0008,
    pio_out_prepare_state   = 14'h0010,
    pio_out_setup_state     = 14'h0020,
    receive_pio_data_state  = 14'h0040,
    dma_in_prepare_state    = 14'h0080,
    send_dma_data_state     = 14'h0100,
    dma_out_prepare_state   = 14'h0200,
    send_dma_activate_state = 14'h0400,
    receive_dma_data_state  = 14'h0800,
    send_status_state       = 14'h1000,
    release_state           = 14'h2000
  } pcd_state_t;

  typedef struct packed {
    pcd_fis_t    kind;
    logic        init_busy;
    logic        init_data_req;
    logic        end_busy;
    logic        end_data_req;
    logic        intr;
    logic        bus_release;
    logic [15:0] byte_count;
    logic [11:0] dword_count;
    logic [7:0]  status;
    logic [7:0]  error;
  } pcd_fis_req_t;

  typedef struct packed {
    logic ready;
    logic finished;
    logic error;
  } pcd_backend_t;

endpackage : pcd_pkg

// ==== tb_top.sv ====
/*
  Self-checking bench for the data phase sequencer: AHB-Lite register
  tasks, a frame-watch task and command sequences for all four modes.
  Assumes the host model answers every request with one done pulse.
*/
`timescale 1ns/1ps

module tb_top;
  import pcd_pkg::*;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic         hsel = 1'b0;
  logic         hwrite = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [31:0]  hwdata = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic [2:0]   hsize = 3'h2;
  logic [3:0]   dly = 4'h0;
  logic [31:0]  hrdata;
  logic [31:0]  rd;
  logic         hready;
  logic         hresp;
  logic         tl_req_valid;
  logic         tl_rx_accept;
  logic         tl_done;
  logic         cmd_active;
  pcd_fis_req_t tl_req;
  pcd_fis_req_t seen;
  pcd_backend_t be = '0;
  int           err_count = 0;
  int           n_compared = 0;

  always #5 clk = ~clk;

  pcd_data_phase DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .tl_req_valid(tl_req_valid), .tl_req(tl_req),
    .tl_done(tl_done), .tl_rx_accept(tl_rx_accept), .be(be), .cmd_active(cmd_active));

  pcd_host_model host (.clk(clk), .reset(reset), .tl_req_valid(tl_req_valid),
    .tl_rx_accept(tl_rx_accept), .dly(dly), .tl_done(tl_done));

  task automatic complete_run;
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdchk

  // Wait for a request or receive window, check it, wait for its end
  task automatic frame(input pcd_fis_t k);
    do @(posedge clk); while (tl_req_valid !== 1'b1 && tl_rx_accept !== 1'b1);
    seen = tl_req;
    if (k == FIS_NONE)
      chk("rx_window", 32'h1, 32'({tl_req_valid, tl_rx_accept}));
    else
      chk("frame_kind", 32'(k), 32'({tl_rx_accept, tl_req.kind}));
    do @(posedge clk); while (tl_done !== 1'b1);
  endtask : frame

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk(OFS_XFER, 32'hffff_ffff, XFER_RST, "xfer_reset");
    rdchk(OFS_REGC, 32'hffff_ffff, REGC_RST, "regc_reset");
    rdchk(OFS_STAT, 32'h0007_3fff, 32'h1, "stat_reset");
    wr(8'h10, 32'hffff_ffff);
    rdchk(8'h10, 32'hffff_ffff, 32'h0, "unmapped");
    wr(OFS_REGC, 32'hffff_ffff);
    rdchk(OFS_REGC, 32'hffff_ffff, 32'h0000_ffff, "regc_rw");
    chk("hresp", 32'h0, 32'(hresp));
    // Two blocks per mode, then finished or error while still ready
    for (int p = 0; p < 4; p++) begin
      dly <= 4'(2 * p);
      wr(OFS_XFER, 32'h0801_0200);
      wr(OFS_REGC, 32'h0000_a5c0 | 32'(p));
      be <= 3'b100;
      wr(OFS_CTRL, 32'(p << CTRL_PROTO_LSB) | 32'h1);
      for (int b = 0; b < 2; b++) begin
        if (p < 2) begin
          frame(FIS_PIO_SETUP);
          chk("setup_bits", 32'h0d, 32'({seen.init_busy, seen.init_data_req, seen.end_busy,
              seen.end_data_req, seen.intr}));
          chk("byte_count", 32'h200, 32'(seen.byte_count));
        end
        if (p == 0)
          frame(FIS_DATA);
        if (p == 1)
          frame(FIS_NONE);
        if (p == 2) begin
          frame(FIS_DATA);
          chk("dwords", 32'h800, 32'(seen.dword_count));
        end
        if (p == 3) begin
          frame(FIS_DMA_ACT);
          frame(FIS_NONE);
        end
      end
      be <= p[0] ? 3'b101 : 3'b110;
      frame(FIS_REG);
      chk("status_frame", 32'h0002_a5c0 | 32'(p),
          32'({seen.intr, seen.bus_release, seen.error, seen.status}));
      repeat (2) @(posedge clk);
      chk("cmd_active", 32'h0, 32'(cmd_active));
      rdchk(OFS_STAT, 32'h0007_3fff, 32'h0001_0001 | 32'(p[0]) << STAT_ERR_BIT, "stat_end");
      rdchk(OFS_STAT, 32'hfff0_0000, (p == 2 ? 32'h3 : 32'h5) << STAT_CNT_LSB, "frame_count");
      wr(OFS_STAT, 32'h0007_0000);
    end
    // Nothing ready with overlap on: release, interrupt as enabled
    for (int p = 0; p < 4; p++) begin
      be <= 3'b000;
      wr(OFS_CTRL, 32'(p << CTRL_PROTO_LSB) | 32'(p[0]) << CTRL_RELIE_BIT | 32'h9);
      frame(FIS_REG);
      chk("release_bits", 32'h2 | 32'(p[0]), 32'({seen.bus_release, seen.intr}));
      repeat (2) @(posedge clk);
      rdchk(OFS_STAT, 32'h0007_3fff, 32'h0002_0001, "stat_released");
      wr(OFS_STAT, 32'h0007_0000);
    end
    // Nothing ready, overlap off: waits, ignores a new start
    be <= 3'b000;
    wr(OFS_CTRL, 32'h7);
    repeat (20) @(posedge clk);
    chk("no_request", 32'h0, 32'({tl_req_valid, tl_rx_accept}));
    chk("cmd_active", 32'h1, 32'(cmd_active));
    wr(OFS_CTRL, 32'h1);
    rdchk(OFS_STAT, 32'h3fff, 32'h0200, "stat_waiting");
    be <= 3'b010;
    frame(FIS_REG);
    chk("final_frame", 32'h2, 32'({seen.intr, seen.bus_release}));
    complete_run();
  end
endmodule : tb_top
